/* File: ppoc_pkg.sv */
// package for the port pad option control block: register offsets, field positions, reset values
// assumes an 8-bit register port with byte offsets inside a small option map
package ppoc_pkg;

	// ==========================================================
	// widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned PORT_W = 8;

	// ==========================================================
	// register offsets
	localparam logic [ADDR_W-1:0] OFS_PULLUP_AB   = 8'h0A;
	localparam logic [ADDR_W-1:0] OFS_PULLUP_C    = 8'h0B;
	localparam logic [ADDR_W-1:0] OFS_OPEN_DR_ADE = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_OPEN_DR_C   = 8'h0D;
	localparam logic [ADDR_W-1:0] OFS_KWU_ENABLES = 8'h0E;
	localparam logic [ADDR_W-1:0] OFS_MASK_STATUS = 8'h0F;

	// ==========================================================
	// pullup_control_ports_ab fields
	localparam int unsigned BIT_PORT_B_UPPER_PULLUP = 3;
	localparam int unsigned BIT_PORT_B_LOWER_PULLUP = 2;
	localparam int unsigned BIT_PORT_A_UPPER_PULLUP = 1;
	localparam int unsigned BIT_PORT_A_LOWER_PULLUP = 0;
	localparam logic [DATA_W-1:0] MASK_PULLUP_AB    = 8'h0F;

	// ==========================================================
	// open_drain_control_ports_ade fields
	localparam int unsigned BIT_PORT_D_UPPER_OPEN_DRAIN = 7;
	localparam int unsigned BIT_PORT_D_LOWER_OPEN_DRAIN = 6;
	localparam int unsigned BIT_PORT_E_UPPER_OPEN_DRAIN = 5;
	localparam int unsigned BIT_PORT_E_LOWER_OPEN_DRAIN = 4;
	localparam int unsigned BIT_PORT_A_UPPER_OPEN_DRAIN = 1;
	localparam int unsigned BIT_PORT_A_LOWER_OPEN_DRAIN = 0;
	localparam logic [DATA_W-1:0] MASK_OPEN_DR_ADE      = 8'hF3;

	// ==========================================================
	// open_drain_control_port_c fields
	localparam logic [DATA_W-1:0] MASK_OPEN_DR_C  = 8'h3F;
	localparam logic [DATA_W-1:0] FIXED_OPEN_DR_C = 8'hC0;

	// ==========================================================
	// mask_option_status fields
	localparam int unsigned BIT_RESET_PIN_PULLUP_FITTED    = 7;
	localparam int unsigned BIT_MAIN_OSC_FEEDBACK_FITTED   = 6;
	localparam int unsigned BIT_SECOND_OSC_FEEDBACK_FITTED = 5;

	// ==========================================================
	// reset values
	localparam logic [DATA_W-1:0] RST_REG  = 8'h00;

endpackage : ppoc_pkg

/* File: ppoc_kwu_if.sv */
// interface between the option block and its key-wakeup detector
// assumes one clock domain; pins are already synchronous
interface ppoc_kwu_if #(
	parameter int unsigned WIDTH = 8
);
	logic [WIDTH-1:0] pins;
	logic [WIDTH-1:0] enables;
	logic             flag_clear;
	logic             flag;

	modport owner (
		output pins,
		output enables,
		output flag_clear,
		input  flag
	);

	modport detector (
		input  pins,
		input  enables,
		input  flag_clear,
		output flag
	);
endinterface : ppoc_kwu_if

/* File: ppoc_kwu.sv */
// key-wakeup detector: one falling-edge latch per pin, all latches cleared together
// assumes pins are synchronous to i_ref_clk and idle high
module ppoc_kwu #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_b,
	ppoc_kwu_if.detector bus
);

	logic [WIDTH-1:0] prev_q;
	logic [WIDTH-1:0] prev_d;
	logic [WIDTH-1:0] latch_q;
	logic [WIDTH-1:0] latch_d;
	logic [WIDTH-1:0] fall;

	// ==========================================================
	// edge latches
	always_comb begin
		prev_d  = bus.pins;
		fall    = prev_q & ~bus.pins & bus.enables;           // [RULE_20]
		latch_d = latch_q;
		if (bus.flag_clear) begin
			latch_d = '0;
		end
		// a new edge in the clearing cycle survives the clear
		latch_d = latch_d | fall;                             // [RULE_20]
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prev_q  <= '1;
			latch_q <= '0;
		end else begin
			prev_q  <= prev_d;
			latch_q <= latch_d;
		end
	end

	assign bus.flag = |latch_q;                               // [RULE_20]

endmodule : ppoc_kwu

/* File: ppoc_top.sv */
// option-map register set steering pullups, open-drain modes and key-wakeup enables of ports a to e
// assumes synchronous pin and display-select inputs and a one-cycle strobe register port

// ==========================================================
// Operation
// RULE_01: port b upper pullup drives pins 7..4
// RULE_02: port b lower pullup drives pins 3..0
// RULE_03: port a upper pullup drives pins 7..4
// RULE_04: port a lower pullup drives pins 3..0
// RULE_05: port c pullup bit per pin
// RULE_06: port d upper open-drain when display selects port
// RULE_07: port d low three open-drain unless backplane used
// RULE_08: port e upper open-drain when general output selected
// RULE_09: port e lower open-drain when general output selected
// RULE_10: open-drain register bits 3,2 read zero
// RULE_11: port a upper open-drain on output pins
// RULE_12: port a lower open-drain on output pins
// RULE_13: port c pins 7,6 always open-drain outputs; the code gates them by i_port_c_pin_direction
// RULE_14: port c open-drain bit per output pin
// RULE_15: key-wakeup enable bit per port b pin
// RULE_16: status bit 7 reports reset pullup option
// RULE_17: status bit 6 reports main oscillator resistor
// RULE_18: status bit 5 reports second oscillator resistor
// RULE_19: unused pullup and status bits read zero
// RULE_20: enabled falling edge sets key-wakeup flag
// RULE_21: reserved and read-only bits ignore writes
module ppoc_top #(
	parameter logic RESET_PIN_PULLUP_FITTED    = 1'b0,
	parameter logic MAIN_OSC_FEEDBACK_FITTED   = 1'b0,
	parameter logic SECOND_OSC_FEEDBACK_FITTED = 1'b0
) (
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_rst_b,
	// register port
	input  wire logic [ppoc_pkg::ADDR_W-1:0]   i_addr,
	input  wire logic [ppoc_pkg::DATA_W-1:0]   i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic      [ppoc_pkg::DATA_W-1:0]   o_rdata,
	// surrounding port and display state
	input  wire logic [ppoc_pkg::PORT_W-1:0]   i_port_a_direction,
	input  wire logic [ppoc_pkg::PORT_W-1:0]   i_port_c_pin_direction,
	input  wire logic                          i_display_port_d_upper_select,
	input  wire logic                          i_display_port_e_upper_select,
	input  wire logic                          i_display_port_e_lower_select,
	input  wire logic [2:0]                    i_display_backplane_pin_used,
	// key wakeup
	input  wire logic [ppoc_pkg::PORT_W-1:0]   i_port_b_pin,
	input  wire logic                          i_key_wakeup_flag_clear,
	output logic                               o_key_wakeup_flag,
	output logic      [ppoc_pkg::PORT_W-1:0]   o_key_wakeup_pin_enable,
	// pad controls
	output logic      [ppoc_pkg::PORT_W-1:0]   o_port_a_pullup,
	output logic      [ppoc_pkg::PORT_W-1:0]   o_port_b_pullup,
	output logic      [ppoc_pkg::PORT_W-1:0]   o_port_c_pullup,
	output logic      [ppoc_pkg::PORT_W-1:0]   o_port_a_open_drain,
	output logic      [ppoc_pkg::PORT_W-1:0]   o_port_c_open_drain,
	output logic      [ppoc_pkg::PORT_W-1:0]   o_port_d_open_drain,
	output logic      [ppoc_pkg::PORT_W-1:0]   o_port_e_open_drain
);

	localparam int unsigned HALF = ppoc_pkg::PORT_W / 2;

	// ==========================================================
	// register state
	logic [ppoc_pkg::DATA_W-1:0] pullup_control_ports_ab_q;
	logic [ppoc_pkg::DATA_W-1:0] pullup_control_ports_ab_d;
	logic [ppoc_pkg::DATA_W-1:0] pullup_control_port_c_q;
	logic [ppoc_pkg::DATA_W-1:0] pullup_control_port_c_d;
	logic [ppoc_pkg::DATA_W-1:0] open_drain_control_ports_ade_q;
	logic [ppoc_pkg::DATA_W-1:0] open_drain_control_ports_ade_d;
	logic [ppoc_pkg::DATA_W-1:0] open_drain_control_port_c_q;
	logic [ppoc_pkg::DATA_W-1:0] open_drain_control_port_c_d;
	logic [ppoc_pkg::DATA_W-1:0] key_wakeup_input_enables_q;
	logic [ppoc_pkg::DATA_W-1:0] key_wakeup_input_enables_d;
	logic [ppoc_pkg::DATA_W-1:0] mask_option_status;
	logic [ppoc_pkg::DATA_W-1:0] rdata_q;
	logic [ppoc_pkg::DATA_W-1:0] rdata_d;

	// ==========================================================
	// pad control state
	logic [ppoc_pkg::PORT_W-1:0] port_a_pullup_q;
	logic [ppoc_pkg::PORT_W-1:0] port_a_pullup_d;
	logic [ppoc_pkg::PORT_W-1:0] port_b_pullup_q;
	logic [ppoc_pkg::PORT_W-1:0] port_b_pullup_d;
	logic [ppoc_pkg::PORT_W-1:0] port_c_pullup_q;
	logic [ppoc_pkg::PORT_W-1:0] port_c_pullup_d;
	logic [ppoc_pkg::PORT_W-1:0] port_a_open_drain_q;
	logic [ppoc_pkg::PORT_W-1:0] port_a_open_drain_d;
	logic [ppoc_pkg::PORT_W-1:0] port_c_open_drain_q;
	logic [ppoc_pkg::PORT_W-1:0] port_c_open_drain_d;
	logic [ppoc_pkg::PORT_W-1:0] port_d_open_drain_q;
	logic [ppoc_pkg::PORT_W-1:0] port_d_open_drain_d;
	logic [ppoc_pkg::PORT_W-1:0] port_e_open_drain_q;
	logic [ppoc_pkg::PORT_W-1:0] port_e_open_drain_d;
	logic [ppoc_pkg::PORT_W-1:0] port_c_od_select;

	// ==========================================================
	// factory options, fixed at build time
	always_comb begin
		mask_option_status = '0;                                                       // [RULE_19]
		mask_option_status[ppoc_pkg::BIT_RESET_PIN_PULLUP_FITTED]    = RESET_PIN_PULLUP_FITTED;    // [RULE_16]
		mask_option_status[ppoc_pkg::BIT_MAIN_OSC_FEEDBACK_FITTED]   = MAIN_OSC_FEEDBACK_FITTED;   // [RULE_17]
		mask_option_status[ppoc_pkg::BIT_SECOND_OSC_FEEDBACK_FITTED] = SECOND_OSC_FEEDBACK_FITTED; // [RULE_18]
	end

	// ==========================================================
	// register writes
	// only implemented bits are stored, so reserved bits stay zero whatever is written
	always_comb begin
		pullup_control_ports_ab_d      = pullup_control_ports_ab_q;
		pullup_control_port_c_d        = pullup_control_port_c_q;
		open_drain_control_ports_ade_d = open_drain_control_ports_ade_q;
		open_drain_control_port_c_d    = open_drain_control_port_c_q;
		key_wakeup_input_enables_d     = key_wakeup_input_enables_q;
		if (i_wr) begin
			case (i_addr)
				ppoc_pkg::OFS_PULLUP_AB: begin
					pullup_control_ports_ab_d = i_wdata & ppoc_pkg::MASK_PULLUP_AB;            // [RULE_19] [RULE_21]
				end
				ppoc_pkg::OFS_PULLUP_C: begin
					pullup_control_port_c_d = i_wdata;                                         // [RULE_05]
				end
				ppoc_pkg::OFS_OPEN_DR_ADE: begin
					open_drain_control_ports_ade_d = i_wdata & ppoc_pkg::MASK_OPEN_DR_ADE;     // [RULE_10] [RULE_21]
				end
				ppoc_pkg::OFS_OPEN_DR_C: begin
					open_drain_control_port_c_d = i_wdata & ppoc_pkg::MASK_OPEN_DR_C;          // [RULE_21]
				end
				ppoc_pkg::OFS_KWU_ENABLES: begin
					key_wakeup_input_enables_d = i_wdata;                                      // [RULE_15]
				end
				default: begin
					// status register and unmapped offsets: nothing stored
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pullup_control_ports_ab_q      <= ppoc_pkg::RST_REG;   // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
			pullup_control_port_c_q        <= ppoc_pkg::RST_REG;   // [RULE_05]
			open_drain_control_ports_ade_q <= ppoc_pkg::RST_REG;   // [RULE_06] [RULE_07] [RULE_08] [RULE_09] [RULE_11] [RULE_12]
			open_drain_control_port_c_q    <= ppoc_pkg::RST_REG;   // [RULE_13] [RULE_14]
			key_wakeup_input_enables_q     <= ppoc_pkg::RST_REG;   // [RULE_15]
		end else begin
			pullup_control_ports_ab_q      <= pullup_control_ports_ab_d;
			pullup_control_port_c_q        <= pullup_control_port_c_d;
			open_drain_control_ports_ade_q <= open_drain_control_ports_ade_d;
			open_drain_control_port_c_q    <= open_drain_control_port_c_d;
			key_wakeup_input_enables_q     <= key_wakeup_input_enables_d;
		end
	end

	// ==========================================================
	// register reads
	// data stand only in the cycle after the strobe; unmapped offsets read zero
	always_comb begin
		rdata_d = '0;
		if (i_rd) begin
			case (i_addr)
				ppoc_pkg::OFS_PULLUP_AB: begin
					rdata_d = pullup_control_ports_ab_q;                                       // [RULE_19]
				end
				ppoc_pkg::OFS_PULLUP_C: begin
					rdata_d = pullup_control_port_c_q;
				end
				ppoc_pkg::OFS_OPEN_DR_ADE: begin
					rdata_d = open_drain_control_ports_ade_q;                                  // [RULE_10]
				end
				ppoc_pkg::OFS_OPEN_DR_C: begin
					rdata_d = open_drain_control_port_c_q | ppoc_pkg::FIXED_OPEN_DR_C;         // [RULE_13]
				end
				ppoc_pkg::OFS_KWU_ENABLES: begin
					rdata_d = key_wakeup_input_enables_q;
				end
				ppoc_pkg::OFS_MASK_STATUS: begin
					rdata_d = mask_option_status;                                              // [RULE_16] [RULE_19]
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_q <= ppoc_pkg::RST_REG;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	// ==========================================================
	// pullup selection
	always_comb begin
		port_a_pullup_d = {{HALF{pullup_control_ports_ab_q[ppoc_pkg::BIT_PORT_A_UPPER_PULLUP]}},   // [RULE_03]
		                   {HALF{pullup_control_ports_ab_q[ppoc_pkg::BIT_PORT_A_LOWER_PULLUP]}}};  // [RULE_04]
		port_b_pullup_d = {{HALF{pullup_control_ports_ab_q[ppoc_pkg::BIT_PORT_B_UPPER_PULLUP]}},   // [RULE_01]
		                   {HALF{pullup_control_ports_ab_q[ppoc_pkg::BIT_PORT_B_LOWER_PULLUP]}}};  // [RULE_02]
		port_c_pullup_d = pullup_control_port_c_q;                                             // [RULE_05]
	end

	// ==========================================================
	// open-drain selection
	// open-drain only means something on a driven pin, so ports a and c are gated by pin direction; ports d and e only by the display selects and backplane use
	always_comb begin
		port_a_open_drain_d = i_port_a_direction &
		                      {{HALF{open_drain_control_ports_ade_q[ppoc_pkg::BIT_PORT_A_UPPER_OPEN_DRAIN]}}, // [RULE_11]
		                       {HALF{open_drain_control_ports_ade_q[ppoc_pkg::BIT_PORT_A_LOWER_OPEN_DRAIN]}}}; // [RULE_12]

		port_c_od_select    = open_drain_control_port_c_q | ppoc_pkg::FIXED_OPEN_DR_C;         // [RULE_13]
		port_c_open_drain_d = i_port_c_pin_direction & port_c_od_select;                       // [RULE_13] [RULE_14]

		port_d_open_drain_d = '0;
		// pin 3 of port d has no open-drain control here and stays push-pull
		port_d_open_drain_d[ppoc_pkg::PORT_W-1:HALF] =
			{HALF{open_drain_control_ports_ade_q[ppoc_pkg::BIT_PORT_D_UPPER_OPEN_DRAIN] &
			      i_display_port_d_upper_select}};                                             // [RULE_06]
		port_d_open_drain_d[2:0] =
			{3{open_drain_control_ports_ade_q[ppoc_pkg::BIT_PORT_D_LOWER_OPEN_DRAIN]}} &
			~i_display_backplane_pin_used;                                                     // [RULE_07]

		port_e_open_drain_d[ppoc_pkg::PORT_W-1:HALF] =
			{HALF{open_drain_control_ports_ade_q[ppoc_pkg::BIT_PORT_E_UPPER_OPEN_DRAIN] &
			      i_display_port_e_upper_select}};                                             // [RULE_08]
		port_e_open_drain_d[HALF-1:0] =
			{HALF{open_drain_control_ports_ade_q[ppoc_pkg::BIT_PORT_E_LOWER_OPEN_DRAIN] &
			      i_display_port_e_lower_select}};                                             // [RULE_09]
	end

	// pad controls are registered: one cycle late, but glitch-free toward the pads
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			port_a_pullup_q     <= ppoc_pkg::RST_REG;
			port_b_pullup_q     <= ppoc_pkg::RST_REG;
			port_c_pullup_q     <= ppoc_pkg::RST_REG;
			port_a_open_drain_q <= ppoc_pkg::RST_REG;
			port_c_open_drain_q <= ppoc_pkg::RST_REG;
			port_d_open_drain_q <= ppoc_pkg::RST_REG;
			port_e_open_drain_q <= ppoc_pkg::RST_REG;
		end else begin
			port_a_pullup_q     <= port_a_pullup_d;
			port_b_pullup_q     <= port_b_pullup_d;
			port_c_pullup_q     <= port_c_pullup_d;
			port_a_open_drain_q <= port_a_open_drain_d;
			port_c_open_drain_q <= port_c_open_drain_d;
			port_d_open_drain_q <= port_d_open_drain_d;
			port_e_open_drain_q <= port_e_open_drain_d;
		end
	end

	assign o_port_a_pullup     = port_a_pullup_q;
	assign o_port_b_pullup     = port_b_pullup_q;
	assign o_port_c_pullup     = port_c_pullup_q;
	assign o_port_a_open_drain = port_a_open_drain_q;
	assign o_port_c_open_drain = port_c_open_drain_q;
	assign o_port_d_open_drain = port_d_open_drain_q;
	assign o_port_e_open_drain = port_e_open_drain_q;

	// ==========================================================
	// key wakeup
	ppoc_kwu_if #(
		.WIDTH (ppoc_pkg::PORT_W)
	) kwu_bus ();

	assign kwu_bus.pins       = i_port_b_pin;
	assign kwu_bus.enables    = key_wakeup_input_enables_q;                                  // [RULE_15]
	assign kwu_bus.flag_clear = i_key_wakeup_flag_clear;

	ppoc_kwu #(
		.WIDTH (ppoc_pkg::PORT_W)
	) u_kwu (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.bus       (kwu_bus.detector)
	);

	assign o_key_wakeup_flag       = kwu_bus.flag;                                          // [RULE_20]
	assign o_key_wakeup_pin_enable = key_wakeup_input_enables_q;                            // [RULE_15]

endmodule : ppoc_top

/* File: ppoc_top_asserts.sv */
// concurrent checks for the port pad option control block
// assumes a bind to ppoc_top and sight of its ports only
module ppoc_top_asserts #(
	parameter logic RESET_PIN_PULLUP_FITTED    = 1'b0,
	parameter logic MAIN_OSC_FEEDBACK_FITTED   = 1'b0,
	parameter logic SECOND_OSC_FEEDBACK_FITTED = 1'b0
) (
	input wire logic       i_ref_clk,
	input wire logic       i_rst_b,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [7:0] i_port_a_direction,
	input wire logic [7:0] i_port_c_pin_direction,
	input wire logic       i_display_port_d_upper_select,
	input wire logic       i_display_port_e_upper_select,
	input wire logic       i_display_port_e_lower_select,
	input wire logic [2:0] i_display_backplane_pin_used,
	input wire logic [7:0] i_port_b_pin,
	input wire logic       i_key_wakeup_flag_clear,
	input wire logic       o_key_wakeup_flag,
	input wire logic [7:0] o_key_wakeup_pin_enable,
	input wire logic [7:0] o_port_a_pullup,
	input wire logic [7:0] o_port_b_pullup,
	input wire logic [7:0] o_port_a_open_drain,
	input wire logic [7:0] o_port_c_open_drain,
	input wire logic [7:0] o_port_d_open_drain,
	input wire logic [7:0] o_port_e_open_drain
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	// ==========================================================
	// register reads
	sequence s_read(logic [7:0] a);
		i_rd && i_addr == a;
	endsequence
	a_status_fixed: assert property (
		s_read(ppoc_pkg::OFS_MASK_STATUS) |=> o_rdata == {RESET_PIN_PULLUP_FITTED, MAIN_OSC_FEEDBACK_FITTED,
		SECOND_OSC_FEEDBACK_FITTED, 5'h00})
		else $error("status read wrong");
	a_ab_unused_zero: assert property (s_read(ppoc_pkg::OFS_PULLUP_AB) |=> o_rdata[7:4] == 4'h0)
		else $error("pullup ab bits 7-4 set");
	a_ade_reserved: assert property (s_read(ppoc_pkg::OFS_OPEN_DR_ADE) |=> o_rdata[3:2] == 2'h0)
		else $error("ade reserved bits set");
	a_c_fixed_ones: assert property (s_read(ppoc_pkg::OFS_OPEN_DR_C) |=> o_rdata[7:6] == 2'h3)
		else $error("port c open drain top bits not one");

	// ==========================================================
	// pad controls
	a_pullup_write: assert property (
		i_wr && i_addr == ppoc_pkg::OFS_PULLUP_AB |-> ##2
		o_port_a_pullup == {{4{$past(i_wdata[1], 2)}}, {4{$past(i_wdata[0], 2)}}} &&
		o_port_b_pullup == {{4{$past(i_wdata[3], 2)}}, {4{$past(i_wdata[2], 2)}}})
		else $error("pullup pads wrong");
	a_od_outputs: assert property (
		(o_port_a_open_drain & ~$past(i_port_a_direction)) == 8'h00 &&
		(o_port_c_open_drain & ~$past(i_port_c_pin_direction)) == 8'h00)
		else $error("open drain on an input pin");
	a_c_top_pins: assert property (
		$past(i_rst_b, 2) |-> o_port_c_open_drain[7:6] == $past(i_port_c_pin_direction[7:6]))
		else $error("port c top pins not open drain");
	a_de_select_gate: assert property (
		($past(i_display_port_d_upper_select) || o_port_d_open_drain[7:4] == 4'h0) &&
		($past(i_display_port_e_upper_select) || o_port_e_open_drain[7:4] == 4'h0) &&
		($past(i_display_port_e_lower_select) || o_port_e_open_drain[3:0] == 4'h0))
		else $error("open drain on a display pin");
	a_d_backplane: assert property (
		(o_port_d_open_drain[2:0] & $past(i_display_backplane_pin_used)) == 3'h0 && !o_port_d_open_drain[3])
		else $error("port d open drain on display pin");

	// ==========================================================
	// key wakeup
	sequence s_key_fall;
		$past(i_rst_b) && |(o_key_wakeup_pin_enable & $past(i_port_b_pin) & ~i_port_b_pin);
	endsequence
	a_kwu_set: assert property (s_key_fall |=> o_key_wakeup_flag)
		else $error("key flag not set");
	a_kwu_hold: assert property (o_key_wakeup_flag && !i_key_wakeup_flag_clear |=> o_key_wakeup_flag)
		else $error("flag dropped without clear");
	a_kwu_clear: assert property (
		i_key_wakeup_flag_clear && !(|(o_key_wakeup_pin_enable & $past(i_port_b_pin) & ~i_port_b_pin))
		|=> !o_key_wakeup_flag)
		else $error("flag not cleared");
endmodule : ppoc_top_asserts

bind ppoc_top ppoc_top_asserts #(
	.RESET_PIN_PULLUP_FITTED   (RESET_PIN_PULLUP_FITTED),
	.MAIN_OSC_FEEDBACK_FITTED  (MAIN_OSC_FEEDBACK_FITTED),
	.SECOND_OSC_FEEDBACK_FITTED(SECOND_OSC_FEEDBACK_FITTED)
) u_asserts (
	.i_ref_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_port_a_direction, .i_port_c_pin_direction,
	.i_display_port_d_upper_select, .i_display_port_e_upper_select, .i_display_port_e_lower_select,
	.i_display_backplane_pin_used, .i_port_b_pin, .i_key_wakeup_flag_clear, .o_key_wakeup_flag,
	.o_key_wakeup_pin_enable, .o_port_a_pullup, .o_port_b_pullup, .o_port_a_open_drain, .o_port_c_open_drain,
	.o_port_d_open_drain, .o_port_e_open_drain
);

/* File: ppoc_pin_model.sv */
// model of the keys wired to port b: a pressed key pulls its pin low
// assumes a pin held by neither key nor pullup floats
module ppoc_pin_model (
	input  wire logic       i_ref_clk,
	input  wire logic [7:0] i_key_down,
	input  wire logic [7:0] i_pullup,
	output logic      [7:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] float_q = 8'h00;

	// ==========================================================
	// pin levels
	// a floating pin wanders every cycle, so a missing pullup shows up as stray edges
	always_ff @(posedge i_ref_clk) begin
		float_q <= ~float_q;
	end
	assign o_pin = ~i_key_down & (i_pullup | float_q);
endmodule : ppoc_pin_model

/* File: ppoc_top_tb.sv */
// self-checking bench for the port pad option control block
// assumes ppoc_top, its checker and the port b key model are compiled first
module ppoc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic RST_PU  = 1'b1;
	localparam logic MAIN_FB = 1'b0;
	localparam logic SEC_FB  = 1'b1;
	localparam logic [7:0] STATUS = {RST_PU, MAIN_FB, SEC_FB, 5'h00};
	logic       i_ref_clk, i_rst_b, i_wr, i_rd, i_kw_clear, d_sel, eu_sel, el_sel, kw_flag;
	logic [7:0] i_addr, i_wdata, o_rdata, dir_a, dir_c, pin_b, key_down, kw_en;
	logic [7:0] pu_a, pu_b, pu_c, od_a, od_c, od_d, od_e;
	logic [2:0] bp_used;
	int         mismatches = 0;
	int         compares = 0;

`define CHK(nm, exp, got) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("mismatch %s expected %h seen %h", nm, exp, got); \
	end \
end

	ppoc_top #(.RESET_PIN_PULLUP_FITTED(RST_PU), .MAIN_OSC_FEEDBACK_FITTED(MAIN_FB),
		.SECOND_OSC_FEEDBACK_FITTED(SEC_FB)) uut (
		.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_port_a_direction(dir_a), .i_port_c_pin_direction(dir_c),
		.i_display_port_d_upper_select(d_sel), .i_display_port_e_upper_select(eu_sel),
		.i_display_port_e_lower_select(el_sel), .i_display_backplane_pin_used(bp_used), .i_port_b_pin(pin_b),
		.i_key_wakeup_flag_clear(i_kw_clear), .o_key_wakeup_flag(kw_flag), .o_key_wakeup_pin_enable(kw_en),
		.o_port_a_pullup(pu_a), .o_port_b_pullup(pu_b), .o_port_c_pullup(pu_c), .o_port_a_open_drain(od_a),
		.o_port_c_open_drain(od_c), .o_port_d_open_drain(od_d), .o_port_e_open_drain(od_e));
	ppoc_pin_model keys (.i_ref_clk(i_ref_clk), .i_key_down(key_down), .i_pullup(pu_b), .o_pin(pin_b));

	// ==========================================================
	// bus and timing helpers
	task automatic wr_reg(input logic [7:0] a, d);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [7:0] a, exp);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		`CHK("o_rdata", exp, o_rdata)
	endtask : rd_chk
	// pads and flag lag one edge behind their cause
	task automatic settle;
		@(posedge i_ref_clk);
		#1;
	endtask : settle

	// ==========================================================
	// scenarios
	task automatic t_reset;
		logic [7:0] offs [6] = '{ppoc_pkg::OFS_PULLUP_AB, ppoc_pkg::OFS_PULLUP_C, ppoc_pkg::OFS_OPEN_DR_ADE,
			ppoc_pkg::OFS_OPEN_DR_C, ppoc_pkg::OFS_KWU_ENABLES, ppoc_pkg::OFS_MASK_STATUS};
		logic [7:0] vals [6] = '{8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, STATUS};
		for (int k = 0; k < 6; k++) begin
			rd_chk(offs[k], vals[k]);
		end
		`CHK("pads", 56'h0, {pu_a, pu_b, pu_c, od_a, od_c, od_d, od_e})
	endtask : t_reset
	task automatic t_pullup;
		logic [3:0] b;
		for (int k = 0; k < 4; k++) begin
			b = 4'h1 << k;
			wr_reg(ppoc_pkg::OFS_PULLUP_AB, {4'hF, b});
			settle();
			`CHK("o_port_a_pullup", {{4{b[1]}}, {4{b[0]}}}, pu_a)
			`CHK("o_port_b_pullup", {{4{b[3]}}, {4{b[2]}}}, pu_b)
			rd_chk(ppoc_pkg::OFS_PULLUP_AB, {4'h0, b});
		end
		wr_reg(ppoc_pkg::OFS_PULLUP_C, 8'h5A);
		settle();
		`CHK("o_port_c_pullup", 8'h5A, pu_c)
		rd_chk(ppoc_pkg::OFS_PULLUP_C, 8'h5A);
	endtask : t_pullup
	task automatic t_od_ac;
		@(posedge i_ref_clk);
		dir_a <= 8'h3C;
		dir_c <= 8'hC3;
		wr_reg(ppoc_pkg::OFS_OPEN_DR_ADE, 8'hFF);
		wr_reg(ppoc_pkg::OFS_OPEN_DR_C, 8'h01);
		settle();
		`CHK("o_port_a_open_drain", 8'h3C, od_a)
		`CHK("o_port_c_open_drain", 8'hC1, od_c)
		rd_chk(ppoc_pkg::OFS_OPEN_DR_ADE, 8'hF3);
		rd_chk(ppoc_pkg::OFS_OPEN_DR_C, 8'hC1);
		wr_reg(ppoc_pkg::OFS_OPEN_DR_ADE, 8'h02);
		@(posedge i_ref_clk);
		dir_c <= 8'h00;
		settle();
		`CHK("o_port_a_open_drain", 8'h30, od_a)
		`CHK("o_port_c_open_drain", 8'h00, od_c)
	endtask : t_od_ac
	task automatic t_od_de;
		logic [2:0] s;
		wr_reg(ppoc_pkg::OFS_OPEN_DR_ADE, 8'hF0);
		for (int k = 0; k < 8; k++) begin
			s = k[2:0];
			@(posedge i_ref_clk);
			d_sel <= s[0];
			eu_sel <= s[1];
			el_sel <= s[2];
			bp_used <= s;
			settle();
			`CHK("o_port_d_open_drain", {{4{s[0]}}, 1'b0, ~s}, od_d)
			`CHK("o_port_e_open_drain", {{4{s[1]}}, {4{s[2]}}}, od_e)
		end
	endtask : t_od_de
	task automatic t_ignore;
		wr_reg(ppoc_pkg::OFS_MASK_STATUS, 8'hFF);
		wr_reg(8'h20, 8'hFF);
		rd_chk(ppoc_pkg::OFS_MASK_STATUS, STATUS);
		rd_chk(8'h20, 8'h00);
		rd_chk(ppoc_pkg::OFS_OPEN_DR_ADE, 8'hF0);
		rd_chk(ppoc_pkg::OFS_PULLUP_C, 8'h5A);
	endtask : t_ignore
	task automatic t_key;
		wr_reg(ppoc_pkg::OFS_PULLUP_AB, 8'h0C);
		wr_reg(ppoc_pkg::OFS_KWU_ENABLES, 8'h10);
		settle();
		settle();
		`CHK("o_key_wakeup_pin_enable", 8'h10, kw_en)
		rd_chk(ppoc_pkg::OFS_KWU_ENABLES, 8'h10);
		@(posedge i_ref_clk);
		key_down <= 8'h08;
		settle();
		settle();
		`CHK("o_key_wakeup_flag", 1'b0, kw_flag)
		@(posedge i_ref_clk);
		key_down <= 8'h10;
		settle();
		`CHK("o_key_wakeup_flag", 1'b1, kw_flag)
		@(posedge i_ref_clk);
		key_down <= 8'h00;
		i_kw_clear <= 1'b1;
		settle();
		`CHK("o_key_wakeup_flag", 1'b0, kw_flag)
		@(posedge i_ref_clk);
		i_kw_clear <= 1'b0;
		@(posedge i_ref_clk);
		key_down <= 8'h10;
		i_kw_clear <= 1'b1;
		settle();
		`CHK("o_key_wakeup_flag", 1'b1, kw_flag)
		@(posedge i_ref_clk);
		i_kw_clear <= 1'b0;
	endtask : t_key

	// ==========================================================
	// run control
	task automatic stop_test;
		if (mismatches == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		{i_rst_b, i_wr, i_rd, i_kw_clear, d_sel, eu_sel, el_sel} = 7'h00;
		{i_addr, i_wdata, dir_a, dir_c, key_down} = 40'h0;
		bp_used = 3'h0;
		repeat (16) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		t_reset();
		t_pullup();
		t_od_ac();
		t_od_de();
		t_ignore();
		t_key();
		stop_test();
	end
	// the whole sequence needs about 120 cycles
	initial begin
		repeat (3000) @(posedge i_ref_clk);
		mismatches++;
		stop_test();
	end
endmodule : ppoc_top_tb
